/* File: src/sram_ctrl_defines.svh */
// timing constants and pin widths for the static memory controller
// assumes a 10 MHz system clock; all strobes are driven from flops
// Operation
// - write happens while select and write strobe are both low
// - read happens with select and output enable low, strobe high
// - write ends at first rising of select or strobe; data timed there
// - read address must be valid no later than select falling
// - controller must not drive data while device outputs still on
// - write address stable 7/8/10 ns before write end
// - write data valid 5/6/8 ns before write end
// - address may change at write end, no hold needed
`ifndef SRAM_CTRL_DEFINES_SVH
`define SRAM_CTRL_DEFINES_SVH

`define ADDR_W            17
`define DATA_W            8
`define CLK_PERIOD_NS     100
// address-to-data access per grade, ns
`define ACCESS_NS_G0      10
`define ACCESS_NS_G1      12
`define ACCESS_NS_G2      15
// write address set-up per grade, ns
`define ADDR_SETUP_NS_G0  7
`define ADDR_SETUP_NS_G1  8
`define ADDR_SETUP_NS_G2  10
// write data set-up per grade, ns
`define DATA_SETUP_NS_G0  5
`define DATA_SETUP_NS_G1  6
`define DATA_SETUP_NS_G2  8
// output disable after enable high per grade, ns
`define HIGHZ_NS_G0       5
`define HIGHZ_NS_G1       6
`define HIGHZ_NS_G2       7

`endif

/* File: src/sram_ctrl_pkg.sv */
// types for the static memory controller
// assumes sram_ctrl_defines.svh gives the widths
`include "sram_ctrl_defines.svh"

package sram_ctrl_pkg;

  typedef enum logic [1:0] {
    GRADE_10,
    GRADE_12,
    GRADE_15
  } speed_grade_t;

  typedef enum {
    ST_IDLE,
    ST_RD_SETUP,
    ST_RD_WAIT,
    ST_WR_SETUP,
    ST_WR_PULSE,
    ST_WR_END
  } ctrl_state_t;

endpackage : sram_ctrl_pkg

/* File: src/sram_ctrl.sv */
// host-side controller for an asynchronous 128k x 8 static memory
// assumes one 10 MHz clock; user requests are synchronous single words
`timescale 1ns/1ns
`include "sram_ctrl_defines.svh"

module sram_ctrl
  import sram_ctrl_pkg::*;
#(
  parameter speed_grade_t GRADE = GRADE_10
)
(
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  input  wire logic                 req_valid,
  input  wire logic                 req_write,
  input  wire logic [`ADDR_W-1:0]   req_addr,
  input  wire logic [`DATA_W-1:0]   req_wdata,
  output      logic                 req_ready,
  output      logic                 rsp_valid,
  output      logic [`DATA_W-1:0]   rsp_rdata,
  output      logic [`ADDR_W-1:0]   address_lines,
  output      logic                 select_n,
  output      logic                 out_enable_n,
  output      logic                 write_strobe_n,
  input  wire logic [`DATA_W-1:0]   data_lines_in,
  output      logic [`DATA_W-1:0]   data_lines_out,
  output      logic                 data_lines_oe_n
);

  // ------------------------------------------------------------------
  // timing per grade
  // ------------------------------------------------------------------
  function automatic int pick(input speed_grade_t g, input int a,
                              input int b, input int c);
    case (g)
      GRADE_10: pick = a;
      GRADE_12: pick = b;
      GRADE_15: pick = c;
      default:  pick = c;
    endcase
  endfunction : pick

  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    cyc_up = (c < 1) ? 1 : c;
  endfunction : cyc_up

  // one grade for every delay
  localparam int ACC_NS  = pick(GRADE, `ACCESS_NS_G0, `ACCESS_NS_G1,
                                `ACCESS_NS_G2);
  localparam int AS_NS   = pick(GRADE, `ADDR_SETUP_NS_G0,
                                `ADDR_SETUP_NS_G1, `ADDR_SETUP_NS_G2);
  localparam int DS_NS   = pick(GRADE, `DATA_SETUP_NS_G0,
                                `DATA_SETUP_NS_G1, `DATA_SETUP_NS_G2);
  localparam int HZ_NS   = pick(GRADE, `HIGHZ_NS_G0, `HIGHZ_NS_G1,
                                `HIGHZ_NS_G2);
  localparam int RD_CYC  = cyc_up(ACC_NS);
  localparam int WR_CYC  = cyc_up((AS_NS > DS_NS) ? AS_NS : DS_NS);
  localparam int HZ_CYC  = cyc_up(HZ_NS);
  localparam int CNT_W   = 4;

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  ctrl_state_t          state_r;
  ctrl_state_t          state_nxt;
  logic [CNT_W-1:0]     cnt_r;
  logic [CNT_W-1:0]     cnt_nxt;
  logic [`ADDR_W-1:0]   addr_r;
  logic [`DATA_W-1:0]   wdata_r;
  logic                 sel_n_r;
  logic                 oe_n_r;
  logic                 we_n_r;
  logic                 drive_n_r;
  logic                 rsp_valid_r;
  logic [`DATA_W-1:0]   rdata_r;

  wire                  cnt_done = (cnt_r == '0);
  wire                  take     = req_valid && req_ready;
  wire                  rd_cap   = (state_r == ST_RD_WAIT) && cnt_done;

  assign req_ready       = (state_r == ST_IDLE);
  assign rsp_valid       = rsp_valid_r;
  assign rsp_rdata       = rdata_r;
  assign address_lines   = addr_r;
  assign select_n        = sel_n_r;
  assign out_enable_n    = oe_n_r;
  assign write_strobe_n  = we_n_r;
  assign data_lines_out  = wdata_r;
  assign data_lines_oe_n = drive_n_r;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_done ? cnt_r : cnt_r - 1'b1;
    case (state_r)
      ST_IDLE:
        if (req_valid)
        begin
          // address set before select falls
          state_nxt = req_write ? ST_WR_SETUP : ST_RD_SETUP;
          cnt_nxt   = req_write ? CNT_W'(HZ_CYC) : '0;
        end
      ST_RD_SETUP:
      begin
        state_nxt = ST_RD_WAIT;
        cnt_nxt   = CNT_W'(RD_CYC); // access delay
      end
      ST_RD_WAIT:
        if (cnt_done)
          state_nxt = ST_IDLE;
      ST_WR_SETUP:
        // bus left idle long enough for device outputs to float
        if (cnt_done)
        begin
          state_nxt = ST_WR_PULSE;
          cnt_nxt   = CNT_W'(WR_CYC); // set-up before write end
        end
      ST_WR_PULSE:
        if (cnt_done)
          state_nxt = ST_WR_END;
      ST_WR_END:
        state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // ------------------------------------------------------------------
  // state and counter
  // ------------------------------------------------------------------
  // counter loads on phase entry and holds at zero
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      state_r <= ST_IDLE;
      cnt_r   <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // ------------------------------------------------------------------
  // request capture
  // ------------------------------------------------------------------
  // one word in flight, so the latch is free while idle
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      addr_r  <= '0;
      wdata_r <= '0;
    end
    else if (take)
    begin
      addr_r  <= req_addr;  // held through write end
      wdata_r <= req_wdata; // stands well before write end
    end
  end

  // ------------------------------------------------------------------
  // read response
  // ------------------------------------------------------------------
  // pulse lasts one cycle; the byte stands until the next read or reset
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      rdata_r     <= '0;
      rsp_valid_r <= 1'b0;
    end
    else
    begin
      rsp_valid_r <= rd_cap;
      if (rd_cap)
        rdata_r <= data_lines_in; // sampled after full access
    end
  end

  // ------------------------------------------------------------------
  // pin decode
  // ------------------------------------------------------------------
  // pins follow the next state, so every strobe leaves a flop
  wire                  rd_phase_nxt = (state_nxt == ST_RD_WAIT);
  wire                  wr_phase_nxt = (state_nxt == ST_WR_PULSE);
  wire                  wr_tail_nxt  = (state_nxt == ST_WR_END);
  // select low for read or write overlap
  wire                  sel_n_nxt    = !(rd_phase_nxt || wr_phase_nxt);
  // read enable, strobe high
  wire                  oe_n_nxt     = !rd_phase_nxt;
  // strobe low; rises with select to end write
  wire                  we_n_nxt     = !wr_phase_nxt;
  // drive data only with output enable high
  wire                  drive_n_nxt  = !(wr_phase_nxt || wr_tail_nxt);

  // ------------------------------------------------------------------
  // pin strobes
  // ------------------------------------------------------------------
  // all four control pins park high: deselect keeps the device in standby
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      sel_n_r   <= 1'b1; // deselected, device in standby
      oe_n_r    <= 1'b1;
      we_n_r    <= 1'b1;
      drive_n_r <= 1'b1;
    end
    else
    begin
      sel_n_r   <= sel_n_nxt;
      oe_n_r    <= oe_n_nxt;
      we_n_r    <= we_n_nxt;
      drive_n_r <= drive_n_nxt;
    end
  end

endmodule : sram_ctrl

/* File: dv/sram_ctrl_monitor.sv */
// checker on the controller ports
// assumes bind into sram_ctrl, one clock
`timescale 1ns/1ns
`include "sram_ctrl_defines.svh"
module sram_ctrl_monitor (
  input wire logic               clk_sys,
  input wire logic               resetn,
  input wire logic               req_valid,
  input wire logic               req_write,
  input wire logic               req_ready,
  input wire logic               rsp_valid,
  input wire logic [`ADDR_W-1:0] address_lines,
  input wire logic               select_n,
  input wire logic               out_enable_n,
  input wire logic               write_strobe_n,
  input wire logic [`DATA_W-1:0] data_lines_out,
  input wire logic               data_lines_oe_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire take = req_valid && req_ready;
  a_no_bus_clash: assert property (!data_lines_oe_n |-> out_enable_n)
    else $error("bus clash");
  a_write_selected: assert property (!write_strobe_n |-> !select_n)
    else $error("strobe without select");
  a_read_no_write: assert property (!out_enable_n |-> write_strobe_n)
    else $error("read with strobe low");
  a_addr_before_sel: assert property (
    $fell(select_n) |-> $stable(address_lines))
    else $error("address moved at select");
  a_addr_held_sel: assert property (
    !select_n |=> $stable(address_lines))
    else $error("address moved while selected");
  a_end_together: assert property (
    $rose(write_strobe_n) |-> $rose(select_n))
    else $error("write end split");
  a_data_held_end: assert property (
    $rose(write_strobe_n) |-> !data_lines_oe_n && $stable(data_lines_out))
    else $error("write data not held");
  a_read_answer: assert property (take && !req_write |-> ##4 rsp_valid)
    else $error("read answer late");
  a_write_busy: assert property (
    take && req_write |=> !req_ready [*5] ##1 req_ready)
    else $error("write length wrong");
endmodule : sram_ctrl_monitor
bind sram_ctrl sram_ctrl_monitor sram_ctrl_monitor_i (.clk_sys, .resetn,
  .req_valid, .req_write, .req_ready, .rsp_valid, .address_lines, .select_n,
  .out_enable_n, .write_strobe_n, .data_lines_out, .data_lines_oe_n);

/* File: dv/sram_model.sv */
// behavioural 128k x 8 static memory
// assumes registered controller pins; resolves the shared data wire
`timescale 1ns/1ns
`include "sram_ctrl_defines.svh"
module sram_model #(
  parameter int ACC_NS = `ACCESS_NS_G0
) (
  input  wire logic [`ADDR_W-1:0] address_lines,
  input  wire logic               select_n,
  input  wire logic               out_enable_n,
  input  wire logic               write_strobe_n,
  input  wire logic [`DATA_W-1:0] data_lines_out,
  input  wire logic               data_lines_oe_n,
  output      logic [`DATA_W-1:0] data_lines_in
);
  logic [`DATA_W-1:0] mem [0:131071];
  logic [`DATA_W-1:0] last_r = 8'h00;
  wire  [`DATA_W-1:0] dev_q;
  wire wr_on = !select_n && !write_strobe_n;
  wire rd_on = !select_n && !out_enable_n && write_strobe_n;
  assign #(ACC_NS) dev_q = rd_on ? mem[address_lines] : ~last_r;
  always @(negedge wr_on) mem[address_lines] = data_lines_in;
  always @(negedge rd_on or posedge data_lines_oe_n) last_r = data_lines_in;
  assign data_lines_in = !data_lines_oe_n ? data_lines_out : dev_q;
endmodule : sram_model

/* File: dv/sram_ctrl_tb.sv */
// self-checking bench for the static memory controller
// assumes sram_model on the pins, inputs driven at falling edge
`timescale 1ns/1ns
`include "sram_ctrl_defines.svh"
module sram_ctrl_tb;
  logic clk_sys, resetn, req_valid, req_write, req_ready, rsp_valid;
  logic select_n, out_enable_n, write_strobe_n, data_lines_oe_n;
  logic [`ADDR_W-1:0] req_addr, address_lines, a;
  logic [`DATA_W-1:0] req_wdata, rsp_rdata, data_lines_in, data_lines_out;
  logic [`DATA_W-1:0] shadow [int];
  logic [`ADDR_W-1:0] addrs [$];
  int errors = 0, check_count = 0, cycles = 0;
  wire [8:0] idle_pins = {5'h00, select_n, out_enable_n, write_strobe_n,
                          data_lines_oe_n};
  sram_ctrl sram_ctrl_i (.clk_sys, .resetn, .req_valid, .req_write,
    .req_addr, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata,
    .address_lines, .select_n, .out_enable_n, .write_strobe_n,
    .data_lines_in, .data_lines_out, .data_lines_oe_n);
  sram_model sram_model_i (.address_lines, .select_n, .out_enable_n,
    .write_strobe_n, .data_lines_out, .data_lines_oe_n, .data_lines_in);
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  function automatic logic [8:0] exp_rsp(input logic [`ADDR_W-1:0] ad);
    return {1'b1, shadow[ad]};
  endfunction : exp_rsp
  task automatic summarize();
    $display("errors=%0d check_count=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  task automatic check_val(input logic [8:0] got, input logic [8:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val
  task automatic send(input logic w, input logic [`ADDR_W-1:0] ad,
                      input logic [`DATA_W-1:0] d);
    int n = 0;
    req_valid = 1'b1;
    req_write = w;
    req_addr = ad;
    req_wdata = d;
    while (req_ready !== 1'b1 && n < 50)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 50)
      errors++;
    @(negedge clk_sys);
    req_valid = 1'b0;
    @(negedge clk_sys);
  endtask : send
  task automatic wr(input logic [`ADDR_W-1:0] ad, input logic [`DATA_W-1:0] d);
    shadow[ad] = d;
    send(1'b1, ad, d);
  endtask : wr
  task automatic rd_chk(input logic [`ADDR_W-1:0] ad);
    int n = 0;
    send(1'b0, ad, 8'($urandom));
    while (rsp_valid !== 1'b1 && n < 20)
    begin
      @(negedge clk_sys);
      n++;
    end
    check_val({rsp_valid, rsp_rdata}, exp_rsp(ad));
  endtask : rd_chk
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors++;
      summarize();
    end
  end
  initial
  begin
    {resetn, req_valid, req_write, req_addr, req_wdata} = '0;
    void'($urandom(84241));
    repeat (16) @(negedge clk_sys);
    check_val(idle_pins, 9'h00F);
    resetn = 1'b1;
    wr(17'h00000, 8'hA5);
    wr(17'h1FFFF, 8'h5A);
    wr(17'h00000, 8'h3C);
    rd_chk(17'h1FFFF);
    rd_chk(17'h00000);
    for (int i = 0; i < 40; i++)
    begin
      a = 17'($urandom);
      addrs.push_back(a);
      wr(a, 8'($urandom));
      if (i % 3 == 0) rd_chk(addrs[$urandom % addrs.size()]);
    end
    resetn = 1'b0;
    repeat (16) @(negedge clk_sys);
    resetn = 1'b1;
    foreach (addrs[i]) rd_chk(addrs[i]);
    summarize();
  end
endmodule : sram_ctrl_tb
